//--- spi_eeprom_pkg.sv
`default_nettype none
package spi_eeprom_pkg;

    // array geometry of the 512-byte variant
    localparam int ADDR_W     = 9;
    localparam int MEM_BYTES  = 512;
    localparam int PAGE_BYTES = 8;
    localparam int COL_W      = 3;
    localparam int PAGE_W     = 6;

    // opcode layout: upper nibble zero, bit 3 carries the ninth address bit
    localparam logic [3:0] OP_HI_NIBBLE   = 4'h0;
    localparam int         OP_A8_BIT      = 3;
    localparam logic [2:0] OP_SET_LATCH   = 3'h6;
    localparam logic [2:0] OP_CLR_LATCH   = 3'h4;
    localparam logic [2:0] OP_STATUS_READ = 3'h5;
    localparam logic [2:0] OP_STATUS_WR   = 3'h1;
    localparam logic [2:0] OP_READ        = 3'h3;
    localparam logic [2:0] OP_WRITE       = 3'h2;

    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // status byte
    localparam logic [7:0] STATUS_BUSY_ALL   = 8'hFF;
    localparam logic [3:0] STATUS_UPPER_IDLE = 4'h0;
    localparam int         STATUS_PROT_LSB   = 2;

    typedef struct packed {
        logic [3:0] upper;
        logic [1:0] protect;
        logic       latch;
        logic       busy;
    } status_s;

    // protection levels and the first protected address of the quarter and half levels
    localparam logic [1:0]        PROT_NONE    = 2'h0;
    localparam logic [1:0]        PROT_QUARTER = 2'h1;
    localparam logic [1:0]        PROT_HALF    = 2'h2;
    localparam logic [1:0]        PROT_ALL     = 2'h3;
    localparam logic [ADDR_W-1:0] QUARTER_BASE = 9'h180;
    localparam logic [ADDR_W-1:0] HALF_BASE    = 9'h100;

    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic        KIND_ARRAY  = 1'b0;
    localparam logic        KIND_STATUS = 1'b1;

    // internal write cycle, longest time rounded down to clk cycles
    localparam int WRITE_TIME_NS = 5000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W    = 18;

    typedef enum logic [7:0] {
        ST_OPCODE   = 8'h01,
        ST_ADDR     = 8'h02,
        ST_RDATA    = 8'h04,
        ST_WDATA    = 8'h08,
        ST_STAT_OUT = 8'h10,
        ST_STAT_IN  = 8'h20,
        ST_DONE     = 8'h40,
        ST_DEAD     = 8'h80
    } frame_state_e;

endpackage
`default_nettype wire

//--- spi_eeprom_slave.sv
// Overview of operation
// - bytes travel msb first; commands start at select fall
// - first byte after select is opcode
// - decode six opcodes, ninth address bit in bit 3
// - bad opcode: ignore input, output off until reselect
// - deselected: ignore input, output off
// - hold pauses transfer, sequence state kept
// - during hold, input ignored, output off from the first sck fall in hold
// - protect pin low aborts writes not yet started
// - enable latch clear at power-up
// - latch sets only with protect pin high
// - clear-latch command works regardless of protect pin
// - status: busy, latch, two protection bits
// - idle bits 7..4 zero; busy reads all ones
// - protection field picks read-only top region
// - protection bits written via latch and write cycle
// - read: opcode, address, then data shifted out
// - continuous read increments address, wraps to zero
// - array write needs pin, latch, unprotected address
// - while busy only status read accepted
// - programming starts when select rises after byte
// - page write increments low three bits only
// - latch clears at end of write cycle
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_slave #(
    parameter int WRITE_CYCLES_P = spi_eeprom_pkg::WRITE_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output var  logic so_q,
    output var  logic so_oe_q
);
    import spi_eeprom_pkg::*;

    // ---------------- clk domain storage ----------------
    logic [7:0]            mem_q [MEM_BYTES];
    logic                  busy_q;
    logic [BUSY_CNT_W-1:0] busy_cnt_q;
    logic                  latch_q;
    logic [1:0]            protect_q;
    logic                  abort_q;
    logic                  cs_m_q, cs_s_q, cs_d_q;
    logic                  wp_m_q, wp_s_q;
    logic                  armed_m_q, armed_s_q;
    logic                  set_m_q, set_s_q, set_d_q;
    logic                  clr_m_q, clr_s_q, clr_d_q;

    // ---------------- sck domain storage ----------------
    logic                  frame_rst;
    frame_state_e          state_q;
    frame_state_e          next_state;
    logic [2:0]            bit_q;
    logic [6:0]            shift_q;
    logic [ADDR_W-1:0]     addr_q;
    logic                  is_write_q;
    logic                  tog_q;
    logic                  tog_seen_q;
    logic [6:0]            out_sr_q;
    logic                  armed_q;
    logic                  kind_q;
    logic [7:0]            page_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q;
    logic [COL_W-1:0]      col_q;
    logic [PAGE_W-1:0]     page_addr_q;
    logic [1:0]            status_new_q;
    logic                  set_tog_q, clr_tog_q;
    logic                  busy_m_q, busy_s_q;
    logic                  latch_m_q, latch_s_q;
    logic [1:0]            prot_m_q, prot_s_q;

    logic                  byte_done;
    logic [7:0]            rx_byte;
    logic [2:0]            op_code;
    logic [7:0]            out_byte;
    status_s               status;

    // deselect ends the frame at once, with or without sck edges
    assign frame_rst = rst | cs_n;
    assign byte_done = (bit_q == BIT_LAST);
    assign rx_byte   = {shift_q, si};
    assign op_code   = rx_byte[2:0];

    // opcode decode; busy refuses all but status read
    always_comb begin
        next_state = ST_DEAD;
        if (rx_byte[7:4] == OP_HI_NIBBLE && !(busy_s_q && op_code != OP_STATUS_READ)) begin
            unique case (op_code)
                OP_SET_LATCH:   next_state = ST_DONE;
                OP_CLR_LATCH:   next_state = ST_DONE;
                OP_STATUS_READ: next_state = ST_STAT_OUT;
                OP_STATUS_WR:   next_state = ST_STAT_IN;
                OP_READ:        next_state = ST_ADDR;
                OP_WRITE:       next_state = ST_ADDR;
                default:        next_state = ST_DEAD;
            endcase
        end
    end

    // status byte as seen from the link side
    always_comb begin
        status.upper   = STATUS_UPPER_IDLE;
        status.protect = prot_s_q;
        status.latch   = latch_s_q;
        status.busy    = 1'b0;
        out_byte       = status;
        if (busy_s_q) begin
            out_byte = STATUS_BUSY_ALL;
        end
        if (state_q == ST_RDATA) begin
            // array is only written while busy, and reads are refused then,
            // so the word is quiet whenever the link samples it
            out_byte = mem_q[addr_q];
        end
    end

    // frame sequencer, shifts on rising sck, hold freezes it
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            state_q    <= ST_OPCODE;
            bit_q      <= BIT_FIRST;
            shift_q    <= 7'h00;
            addr_q     <= 9'h000;
            is_write_q <= 1'b0;
            tog_q      <= 1'b0;
        end else if (hold_n) begin
            tog_q   <= ~tog_q;
            bit_q   <= bit_q + 3'h1;
            shift_q <= {shift_q[5:0], si};
            if (byte_done) begin
                unique case (state_q)
                    ST_OPCODE: begin
                        state_q    <= next_state;
                        addr_q     <= {rx_byte[OP_A8_BIT], 8'h00};
                        is_write_q <= (op_code == OP_WRITE);
                    end
                    ST_ADDR: begin
                        addr_q  <= {addr_q[ADDR_W-1], rx_byte};
                        state_q <= is_write_q ? ST_WDATA : ST_RDATA;
                    end
                    ST_RDATA: begin
                        addr_q <= addr_q + 9'h001;
                    end
                    ST_STAT_IN: begin
                        state_q <= ST_DONE;
                    end
                    ST_WDATA, ST_STAT_OUT, ST_DONE, ST_DEAD: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    // output shifter on falling sck; only advances after an accepted rise
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            so_q       <= 1'b0;
            so_oe_q    <= 1'b0;
            out_sr_q   <= 7'h00;
            tog_seen_q <= 1'b0;
        end else begin
            so_oe_q <= hold_n && (state_q == ST_RDATA || state_q == ST_STAT_OUT);
            if (hold_n && tog_q != tog_seen_q) begin
                tog_seen_q <= tog_q;
                if (bit_q == BIT_FIRST) begin
                    so_q     <= out_byte[7];
                    out_sr_q <= out_byte[6:0];
                end else begin
                    so_q     <= out_sr_q[6];
                    out_sr_q <= {out_sr_q[5:0], 1'b0};
                end
            end
        end
    end

    // write arming and latch events; survive deselect for the clk side
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            armed_q      <= 1'b0;
            kind_q       <= KIND_ARRAY;
            status_new_q <= PROT_NONE;
            set_tog_q    <= 1'b0;
            clr_tog_q    <= 1'b0;
        end else if (!cs_n && hold_n) begin
            // armed only if the last bit closed a data byte
            armed_q <= byte_done && (state_q == ST_WDATA || state_q == ST_STAT_IN);
            if (byte_done && state_q == ST_OPCODE && next_state == ST_DONE) begin
                if (op_code == OP_SET_LATCH) begin
                    set_tog_q <= ~set_tog_q;
                end else begin
                    clr_tog_q <= ~clr_tog_q;
                end
            end
            if (byte_done && state_q == ST_OPCODE && next_state == ST_STAT_IN) begin
                kind_q <= KIND_STATUS;
            end
            if (byte_done && state_q == ST_OPCODE && next_state == ST_ADDR) begin
                kind_q <= KIND_ARRAY;
            end
            if (byte_done && state_q == ST_STAT_IN) begin
                status_new_q <= rx_byte[STATUS_PROT_LSB +: 2];
            end
        end
    end

    // page buffer; column wraps inside the page
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            mask_q      <= '0;
            col_q       <= '0;
            page_addr_q <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_q[i] <= 8'h00;
            end
        end else if (!cs_n && hold_n && byte_done) begin
            if (state_q == ST_OPCODE && next_state == ST_ADDR && op_code == OP_WRITE) begin
                mask_q <= '0;
            end
            if (state_q == ST_ADDR && is_write_q) begin
                page_addr_q <= {addr_q[ADDR_W-1], rx_byte[7:COL_W]};
                col_q       <= rx_byte[COL_W-1:0];
            end
            if (state_q == ST_WDATA) begin
                page_q[col_q] <= rx_byte;
                mask_q[col_q] <= 1'b1;
                col_q         <= col_q + 3'h1;
            end
        end
    end

    // clk-side state into the link domain; valid from the third edge of a frame
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            busy_m_q  <= 1'b0;
            busy_s_q  <= 1'b0;
            latch_m_q <= 1'b0;
            latch_s_q <= 1'b0;
            prot_m_q  <= PROT_NONE;
            prot_s_q  <= PROT_NONE;
        end else begin
            busy_m_q  <= busy_q;
            busy_s_q  <= busy_m_q;
            latch_m_q <= latch_q;
            latch_s_q <= latch_m_q;
            prot_m_q  <= protect_q;
            prot_s_q  <= prot_m_q;
        end
    end

    // ---------------- clk domain ----------------

    // pin and event synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_m_q    <= 1'b1;
            cs_s_q    <= 1'b1;
            cs_d_q    <= 1'b1;
            wp_m_q    <= 1'b0;
            wp_s_q    <= 1'b0;
            armed_m_q <= 1'b0;
            armed_s_q <= 1'b0;
            set_m_q   <= 1'b0;
            set_s_q   <= 1'b0;
            set_d_q   <= 1'b0;
            clr_m_q   <= 1'b0;
            clr_s_q   <= 1'b0;
            clr_d_q   <= 1'b0;
        end else begin
            cs_m_q    <= cs_n;
            cs_s_q    <= cs_m_q;
            cs_d_q    <= cs_s_q;
            wp_m_q    <= wp_n;
            wp_s_q    <= wp_m_q;
            armed_m_q <= armed_q;
            armed_s_q <= armed_m_q;
            set_m_q   <= set_tog_q;
            set_s_q   <= set_m_q;
            set_d_q   <= set_s_q;
            clr_m_q   <= clr_tog_q;
            clr_s_q   <= clr_m_q;
            clr_d_q   <= clr_s_q;
        end
    end

    logic              cs_rise, cs_fall, set_evt, clr_evt;
    logic              in_protected, commit, write_end;
    logic [ADDR_W-1:0] page_base;

    assign cs_rise   = cs_s_q & ~cs_d_q;
    assign cs_fall   = ~cs_s_q & cs_d_q;
    assign set_evt   = set_s_q ^ set_d_q;
    assign clr_evt   = clr_s_q ^ clr_d_q;
    assign page_base = {page_addr_q, 3'h0};
    assign write_end = busy_q && (busy_cnt_q == '0);

    // protected region check; regions are page aligned
    always_comb begin
        unique case (protect_q)
            PROT_NONE:    in_protected = 1'b0;
            PROT_QUARTER: in_protected = (page_base >= QUARTER_BASE);
            PROT_HALF:    in_protected = (page_base >= HALF_BASE);
            PROT_ALL:     in_protected = 1'b1;
        endcase
    end

    // page buffer is quiet from select rise until the next write opcode
    assign commit = cs_rise && armed_s_q && !busy_q && latch_q && !abort_q && wp_s_q
                    && (kind_q == KIND_STATUS || !in_protected);

    // protect pin low during a frame kills that frame's write; set beats clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            abort_q <= 1'b0;
        end else if (!cs_s_q && !wp_s_q) begin
            abort_q <= 1'b1;
        end else if (cs_fall) begin
            abort_q <= 1'b0;
        end
    end

    // internal write cycle timer; once started the pin cannot stop it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= '0;
        end else if (commit) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= BUSY_CNT_W'(WRITE_CYCLES_P - 1);
        end else if (write_end) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q - 18'h00001;
        end
    end

    // enable latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q <= 1'b0;
        end else if (set_evt && wp_s_q && !busy_q) begin
            latch_q <= 1'b1;
        end else if (clr_evt || write_end) begin
            latch_q <= 1'b0;
        end
    end

    // protection bits, modelled non-volatile across frames
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            protect_q <= PROT_NONE;
        end else if (commit && kind_q == KIND_STATUS) begin
            protect_q <= status_new_q;
        end
    end

    // array: all received page bytes land at the start of the cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem_q[i] <= ERASED_BYTE;
            end
        end else if (commit && kind_q == KIND_ARRAY) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_q[i]) begin
                    mem_q[{page_addr_q, 3'(i)}] <= page_q[i];
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- spi_eeprom_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_q,
    input wire logic so_oe_q
);
    logic [5:0] bits_q;
    logic [7:0] op_q;
    logic       on_q;

    // accepted bits, first byte and first drive of the frame; deselect clears all
    always_ff @(posedge sck or posedge cs_n or posedge rst) begin
        if (rst || cs_n) begin
            bits_q <= 6'h00;
            op_q   <= 8'h00;
            on_q   <= 1'b0;
        end else begin
            if (hold_n && bits_q != 6'h3F) bits_q <= bits_q + 6'h01;
            if (hold_n && bits_q < 6'h08) op_q <= {op_q[6:0], si};
            if (so_oe_q) on_q <= 1'b1;
        end
    end

    desel_off_a: assert property (@(posedge clk) disable iff (rst) cs_n |-> !so_oe_q)
        else $error("output driven while deselected");
    oe_launch_a: assert property (@(posedge clk) disable iff (rst)
        $rose(so_oe_q) && !cs_n |-> !sck) else $error("output enabled outside sck low");
    so_shift_a: assert property (@(posedge clk) disable iff (rst || cs_n)
        $changed(so_q) |-> !sck) else $error("output bit changed outside sck low");
    hold_off_a: assert property (@(posedge sck) disable iff (rst || cs_n)
        !hold_n && $past(!hold_n) |-> !so_oe_q) else $error("output driven in hold");
    first_drive_a: assert property (@(posedge sck) disable iff (rst || cs_n)
        $rose(so_oe_q) && !on_q |-> op_q[7:4] == 4'h0 && ((bits_q == 6'h08 && op_q[2:0] == 3'h5)
        || (bits_q == 6'h10 && op_q[2:0] == 3'h3))) else $error("output started wrongly");
    early_drive_a: assert property (@(posedge sck) disable iff (rst || cs_n)
        so_oe_q |-> bits_q >= 6'h08) else $error("output driven inside opcode");
    oe_drop_a: assert property (@(posedge clk) disable iff (rst)
        $fell(so_oe_q) |-> cs_n || !hold_n) else $error("output dropped without cause");
    hold_back_a: assert property (@(posedge sck) disable iff (rst || cs_n)
        on_q && hold_n && $past(hold_n) && $past(hold_n, 2) |-> so_oe_q)
        else $error("output stream broke off");

    c_status: cover property (@(posedge sck) $rose(so_oe_q) && bits_q == 6'h08);
    c_read: cover property (@(posedge sck) $rose(so_oe_q) && bits_q == 6'h10);
    c_hold: cover property (@(posedge sck) !hold_n && $past(!hold_n) && on_q);
endmodule
bind spi_eeprom_slave spi_eeprom_monitor u_spi_eeprom_monitor (.clk(clk), .rst(rst),
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_q(so_q),
    .so_oe_q(so_oe_q));
`default_nettype wire

//--- spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input  wire logic        so_q,
    input  wire logic        so_oe_q,
    output var  logic        sck,
    output var  logic        cs_n,
    output var  logic        si,
    output var  logic        hold_n,
    output var  logic [63:0] rx,
    output var  logic        rx_v
);
    initial begin
        sck    = 1'b0;
        cs_n   = 1'b1;
        si     = 1'b0;
        hold_n = 1'b1;
        rx     = 64'h0;
        rx_v   = 1'b0;
    end

    // one framed transfer, msb first; sck stands still between frames
    task automatic xfer(input int n, input logic [63:0] tx, input int hold_at);
        int i;
        int k;
        logic last;
        last = 1'b0;
        rx = 64'h0;
        cs_n = 1'b0;
        #40;
        for (i = n - 1; i >= 0; i--) begin
            if (i == hold_at) begin
                #8 hold_n = 1'b0;
                for (k = 0; k < 6; k++) begin
                    #32 sck = ~sck;
                    si = ~si;
                end
                #16 hold_n = 1'b1;
            end
            si = tx[i];
            #32 sck = 1'b1;
            // a released output shows the inverse of the last level seen
            rx[i] = so_oe_q ? so_q : ~last;
            last = rx[i];
            #32 sck = 1'b0;
        end
        #16 cs_n = 1'b1;
        si = ~si;
        rx_v = 1'b1;
        #200 rx_v = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- spi_serial_eeprom_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_serial_eeprom_slave_test;
    import spi_eeprom_pkg::*;
    localparam int WC = 200;
    logic        clk, rst, sck, cs_n, si, hold_n, wp_n, so_q, so_oe_q, rx_v;
    logic [63:0] rx;
    logic [63:0] exp_q[$];
    logic [63:0] msk_q[$];
    logic [31:0] seed_q;
    logic [7:0]  d0, d1, d2, d3, r;
    int          miscompares, cmp_count;

    spi_eeprom_slave #(.WRITE_CYCLES_P(WC)) u_spi_eeprom_slave (.clk(clk), .rst(rst),
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_q(so_q),
        .so_oe_q(so_oe_q));
    spi_master_model u_spi_master_model (.so_q(so_q), .so_oe_q(so_oe_q), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .rx(rx), .rx_v(rx_v));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // one step of the bench's 32-bit lfsr
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd(output logic [7:0] v);
        seed_q = lfsr_next(seed_q);
        v = seed_q[7:0];
    endtask
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // driver notes the expectation first, then runs the frame
    task automatic xf(input int n, input logic [63:0] tx, input logic [63:0] m,
                      input logic [63:0] e, input int h = -1);
        exp_q.push_back(e);
        msk_q.push_back(m);
        u_spi_master_model.xfer(n, tx, h);
    endtask
    task automatic st(input logic [7:0] m, input logic [7:0] e, input logic [7:0] op = 8'h05);
        rnd(r);
        xf(16, {op, r}, m, e);
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        xf(24, {4'h0, a[8], 3'h2, a[7:0], d}, 64'h0, 64'h0);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        rnd(r);
        xf(24, {4'h0, a[8], 3'h3, a[7:0], r}, 64'hFF, e);
    endtask
    task automatic cmd(input logic [7:0] op);
        xf(8, op, 64'h0, 64'h0);
    endtask
    task automatic set_wp(input logic v);
        @(posedge clk) wp_n <= v;
    endtask

    // watcher: oldest note against each finished frame
    always @(posedge rx_v) begin
        logic [63:0] m;
        logic [63:0] e;
        m = msk_q.pop_front();
        e = exp_q.pop_front();
        if (m != 64'h0) chk("frame", rx & m, e);
    end

    // hang guard, far beyond the expected run of some 120 us
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        seed_q = 32'h00012FFA;
        miscompares = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rnd(d0);
        rnd(d1);
        rnd(d2);
        rnd(d3);
        st(8'hFF, 8'h00);
        wr(9'h000, d0);
        st(8'hFF, 8'h00);
        cmd(8'h06);
        st(8'hFF, 8'h02);
        set_wp(1'b0);
        cmd(8'h04);
        st(8'hFF, 8'h00);
        cmd(8'h0E);
        st(8'hFF, 8'h00);
        set_wp(1'b1);
        // page write crossing the page end, then busy poll
        cmd(8'h06);
        xf(40, {8'h0A, 8'hFE, d0, d1, d2}, 64'h0, 64'h0);
        st(8'hFF, 8'hFF, 8'h0D);
        cmd(8'h06);
        wr(9'h011, d3);
        #(WC * 25 + 500);
        st(8'hFF, 8'h00);
        rd(9'h011, 8'hFF);
        rnd(r);
        // output returns only on the first fall after resume, so the bit
        // sampled right after a toggled hold meets a released line
        xf(48, {8'h0B, 8'hFE, r, r, r, r}, 64'hFFFFFFFF,
           {d0[7], ~d0[7], d0[5:0], d1, 8'hFF, 8'hFF}, 30);
        rd(9'h1F8, d2);
        // protect pin pulled low while a write is still shifting in
        cmd(8'h06);
        fork
            wr(9'h020, d3);
            begin
                #900;
                set_wp(1'b0);
                repeat (4) @(posedge clk);
                set_wp(1'b1);
            end
        join
        st(8'h01, 8'h00);
        rd(9'h020, 8'hFF);
        for (int lv = 3; lv >= 0; lv--) begin
            cmd(8'h06);
            xf(16, {8'h01, 4'h0, lv[1:0], 2'h0}, 64'h0, 64'h0);
            st(8'hFF, 8'hFF);
            #(WC * 25 + 500);
            st(8'hFF, {4'h0, lv[1:0], 2'h0});
            cmd(8'h06);
            rnd(d0);
            wr(9'h180, d0);
            st(8'h01, {7'h0, lv == 0});
        end
        #(WC * 25 + 500);
        rd(9'h180, d0);
        // dead opcodes keep the output off; a released line reads as 1010...
        for (int i = 0; i < 8; i++) begin
            rnd(r);
            xf(24, {i[0] ? 8'h07 : 8'h13, r, r}, 64'hFFFFFF, 64'hAAAAAA);
        end
        st(8'hFF, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
